/* ubh_pkg.sv */
// package: constants and state types for the usart line block
package ubh_pkg;
    typedef logic [3:0] ubh_mode_t;
    localparam ubh_mode_t MODE_HANDSHAKE = 4'h2;
    localparam ubh_mode_t MODE_T0 = 4'h4;
    localparam ubh_mode_t MODE_T1 = 4'h5;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] RX_START_PHASE = 4'h8;
    localparam logic [3:0] DATA_FRAME = 4'h9;
    localparam logic [3:0] RX_LEN_SHORT = 4'ha;
    localparam logic [3:0] RX_LEN_LONG = 4'hb;
    localparam logic [3:0] T0_GUARD_BITS = 4'h2;
    localparam logic [4:0] NACK_LOW_FROM = 5'h08;
    localparam logic [4:0] NACK_END = 5'h18;
    localparam logic [1:0] EOB_ASYNC = 2'h2;
    localparam logic [1:0] EOB_SYNC = 2'h1;
    localparam logic [7:0] BRK_HIGH_MIN = 8'h0c;
    localparam logic [7:0] ERR_MAX = 8'hff;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001, TX_SHIFT = 4'b0010, TX_BRK_LOW = 4'b0100, TX_BRK_HIGH = 4'b1000
    } ubh_tx_state_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001, RX_BITS = 4'b0010, RX_NACK = 4'b0100, RX_BRK = 4'b1000
    } ubh_rx_state_t;
endpackage : ubh_pkg

/* ubh_line.sv */
// usart line logic: break, framing, handshake, smart-card, receive fifo
`timescale 1ns/1ns
// ==========================================
// input synchroniser
module ubh_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic [2:0] ff;
    logic [2:0] next_ff;
    logic next_level;
    always_comb begin
        next_ff = {ff[1:0], pin};
        next_level = (ff[1] == ff[2]) ? ff[2] : level;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ff <= {3{INIT}};
            level <= INIT;
        end else begin
            ff <= next_ff;
            level <= next_level;
        end
    end
endmodule : ubh_sync
// ==========================================
// receive fifo
module ubh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic do_push, do_pop;
    always_comb begin
        in_ready = (count != DEPTH[AW:0]);
        out_valid = (count != '0);
        out_data = mem[rd_ptr];
        do_push = in_valid && in_ready;
        do_pop = out_valid && out_ready;
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule : ubh_fifo
// ==========================================
// top: line logic
module ubh_line #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic baud_tick16,
    input wire logic card_clk,
    input wire logic sync_mode,
    input wire ubh_pkg::ubh_mode_t op_mode,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic msb_first_select,
    input wire logic stop2,
    input wire logic [7:0] tg_bits,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic rx_dma_buffer_full,
    input wire logic clear_status_cmd,
    input wire logic break_start_cmd,
    input wire logic break_stop_cmd,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    output logic tx_holding_free,
    output logic tx_all_done,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic frame_error_flag,
    output logic break_seen_flag,
    output logic parity_error_flag,
    input wire logic error_count_read,
    output logic [7:0] error_tally,
    input wire logic rxd_in,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic cts_in,
    output logic rts_out,
    output logic sck_out
);
    import ubh_pkg::*;
    function automatic logic [7:0] ubh_order(input logic [7:0] d, input logic msb);
        logic [7:0] r;
        r = d;
        if (msb) begin
            for (int i = 0; i < 8; i++) r[i] = d[7-i];
        end
        return r;
    endfunction : ubh_order
    // ==========================================
    // pins and mode decode
    logic rxd_s, io_s, cts_s;
    ubh_sync #(.INIT(1'b1)) u_rxd (.clk_sys(clk_sys), .rst_n(rst_n), .pin(rxd_in), .level(rxd_s));
    ubh_sync #(.INIT(1'b1)) u_io (.clk_sys(clk_sys), .rst_n(rst_n), .pin(txd_in), .level(io_s));
    ubh_sync #(.INIT(1'b1)) u_cts (.clk_sys(clk_sys), .rst_n(rst_n), .pin(cts_in), .level(cts_s));
    logic hs, t0, t1, smart, pe;
    logic [3:0] nstop, tx_len, rx_len;
    logic [7:0] hold_bits;
    always_comb begin
        hs = (op_mode == MODE_HANDSHAKE);
        t0 = (op_mode == MODE_T0);
        t1 = (op_mode == MODE_T1);
        smart = t0 || t1;
        pe = smart || par_en; // smart modes force parity on; par_odd still sets its sense
        nstop = (t0 || (stop2 && !t1)) ? T0_GUARD_BITS : 4'h1;
        tx_len = DATA_FRAME + {3'h0, pe} + nstop;
        rx_len = (t0 || !pe) ? RX_LEN_SHORT : RX_LEN_LONG;
        hold_bits = (tg_bits > BRK_HIGH_MIN) ? tg_bits : BRK_HIGH_MIN;
    end
    // ==========================================
    // transmitter and break
    ubh_tx_state_t tx_state, next_tx_state;
    logic [7:0] thr, next_thr, brk_bits, next_brk_bits, tx_ord;
    logic [11:0] shreg, next_shreg;
    logic [3:0] bits_left, next_bits_left, tcnt, next_tcnt;
    logic thr_full, next_thr_full, brk_pending, next_brk_pending, brk_stop, next_brk_stop;
    logic bit_tick, in_break, brk_start_ok, brk_stop_ok, tx_par;
    always_comb begin
        tx_ord = ubh_order(thr, msb_first_select);
        tx_par = ^tx_ord ^ par_odd;
        bit_tick = baud_tick16 && (tcnt == TICK_LAST);
        in_break = (tx_state == TX_BRK_LOW) || (tx_state == TX_BRK_HIGH);
        tx_holding_free = !thr_full && !brk_pending;
        tx_all_done = (tx_state == TX_IDLE) && tx_holding_free;
        brk_start_ok = break_start_cmd && tx_holding_free && !in_break;
        brk_stop_ok = break_stop_cmd && tx_holding_free && (tx_state == TX_BRK_LOW);
        next_tx_state = tx_state;
        next_thr = thr;
        next_thr_full = thr_full;
        next_shreg = shreg;
        next_bits_left = bits_left;
        next_tcnt = tcnt;
        next_brk_pending = brk_pending || brk_start_ok;
        next_brk_stop = brk_stop || brk_stop_ok;
        next_brk_bits = brk_bits;
        if (tx_write && !thr_full && !brk_pending) begin // pending break drops it
            next_thr = tx_data;
            next_thr_full = 1'b1;
        end
        if (baud_tick16) begin
            next_tcnt = tcnt + 4'h1;
        end
        if (bit_tick && brk_bits != ERR_MAX) begin
            next_brk_bits = brk_bits + 8'h01;
        end
        unique case (tx_state)
            TX_IDLE: begin
                next_tcnt = 4'h0;
                next_brk_bits = 8'h00;
                if (brk_pending) begin // waits for the shifter to go idle
                    next_tx_state = TX_BRK_LOW;
                    next_brk_pending = 1'b0;
                    next_brk_stop = 1'b0;
                end else if (thr_full && tx_enable && !(hs && cts_s)) begin
                    next_shreg = {2'b11, pe ? tx_par : 1'b1, tx_ord, 1'b0};
                    next_bits_left = tx_len;
                    next_thr_full = 1'b0;
                    next_tx_state = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (bit_tick) begin
                    next_shreg = {1'b1, shreg[11:1]};
                    next_bits_left = bits_left - 4'h1;
                    if (bits_left == 4'h1) next_tx_state = TX_IDLE;
                end
            end
            TX_BRK_LOW: begin
                // a full character of low time is kept even if the stop came early
                if (bit_tick && brk_stop && (brk_bits + 8'h01 >= {4'h0, tx_len})) begin
                    next_tx_state = TX_BRK_HIGH;
                    next_brk_bits = 8'h00;
                    next_brk_stop = 1'b0;
                end
            end
            TX_BRK_HIGH: begin
                if (bit_tick && (brk_bits + 8'h01 >= hold_bits)) next_tx_state = TX_IDLE;
            end
        endcase
    end
    // ==========================================
    // receiver, flags and error tally
    ubh_rx_state_t rx_state, next_rx_state;
    logic [10:0] rsh, next_rsh, v, al;
    logic [3:0] rcnt, next_rcnt, ridx, next_ridx;
    logic [4:0] ncnt, next_ncnt;
    logic [1:0] eob, next_eob, eob_need;
    logic [7:0] rdata, next_rdata, next_tally, raw;
    logic rx_line, push, next_push, err_evt, perr, zero, stop_bit, fifo_in_ready, rx_prev;
    logic set_frame, set_brk, set_par, next_frame, next_brk, next_par;
    always_comb begin
        rx_line = smart ? io_s : rxd_s; // card line feeds the receiver
        eob_need = sync_mode ? EOB_SYNC : EOB_ASYNC;
        v = {rx_line, rsh[10:1]};
        al = (rx_len == RX_LEN_LONG) ? v : {1'b1, v[10:1]};
        raw = al[8:1];
        stop_bit = pe ? al[10] : al[9];
        perr = pe && (^raw ^ al[9] ^ par_odd);
        zero = (raw == 8'h00) && !(pe && al[9]);
        next_rx_state = rx_state;
        next_rsh = rsh;
        next_rcnt = rcnt;
        next_ridx = ridx;
        next_ncnt = ncnt;
        next_eob = eob;
        next_rdata = rdata;
        next_push = 1'b0;
        err_evt = 1'b0;
        set_frame = 1'b0;
        set_brk = 1'b0;
        set_par = 1'b0;
        unique case (rx_state)
            RX_IDLE: begin
                // only a falling edge starts a character: a low stop bit or our own nack must not
                if (rx_enable && rx_prev && !rx_line) begin
                    next_rx_state = RX_BITS;
                    next_rcnt = RX_START_PHASE;
                    next_ridx = 4'h0;
                end
            end
            RX_BITS: begin
                if (baud_tick16) begin
                    next_rcnt = rcnt + 4'h1;
                    if (rcnt == TICK_LAST) begin
                        next_rsh = v;
                        next_ridx = ridx + 4'h1;
                        next_rdata = ubh_order(raw, msb_first_select);
                        if (ridx == 4'h0 && rx_line) begin
                            next_rx_state = RX_IDLE; // glitch, not a start bit
                        end else if (ridx + 4'h1 == rx_len) begin
                            next_rx_state = RX_IDLE;
                            if (!stop_bit && zero) begin
                                set_brk = 1'b1;
                                next_eob = 2'h0;
                                next_rx_state = RX_BRK;
                            end else if (!stop_bit) begin
                                set_frame = 1'b1;
                                err_evt = 1'b1;
                                next_push = 1'b1;
                            end else if (perr) begin
                                set_par = 1'b1;
                                err_evt = 1'b1;
                                next_push = !t0; // t0 drops the bad character
                                next_ncnt = 5'h00;
                                if (t0) next_rx_state = RX_NACK;
                            end else begin
                                next_push = 1'b1;
                            end
                        end
                    end
                end
            end
            RX_NACK: begin
                if (baud_tick16) begin
                    next_ncnt = ncnt + 5'h01;
                    if (ncnt + 5'h01 == NACK_END) next_rx_state = RX_IDLE;
                end
            end
            RX_BRK: begin
                if (baud_tick16) begin
                    next_eob = rx_line ? eob + 2'h1 : 2'h0;
                    if (rx_line && (eob + 2'h1 == eob_need)) begin
                        set_brk = 1'b1; // end of break
                        next_rx_state = RX_IDLE;
                    end
                end
            end
        endcase
        // set wins over a clear in the same cycle
        next_frame = (frame_error_flag && !clear_status_cmd) || set_frame;
        next_brk = (break_seen_flag && !clear_status_cmd) || set_brk;
        next_par = (parity_error_flag && !clear_status_cmd) || set_par;
        next_tally = error_count_read ? 8'h00 : error_tally;
        if (err_evt && next_tally != ERR_MAX) next_tally = next_tally + 8'h01;
    end
    // in handshake mode fifo full reaches the remote through rts; a char arriving while full is lost
    ubh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys), .rst_n(rst_n), .in_valid(push), .in_ready(fifo_in_ready),
        .in_data(rdata), .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
    );
    // ==========================================
    // pin drive
    logic nack_low, next_txd_out, next_txd_oe, next_rts, next_sck;
    always_comb begin
        nack_low = (rx_state == RX_NACK) && (ncnt >= NACK_LOW_FROM);
        next_txd_out = !nack_low && (tx_state == TX_SHIFT ? shreg[0] : tx_state != TX_BRK_LOW);
        next_txd_oe = !smart || nack_low || (tx_state == TX_BRK_LOW) ||
            (tx_state == TX_SHIFT && !(t0 && bits_left <= T0_GUARD_BITS));
        next_rts = hs && (!rx_enable || rx_dma_buffer_full || !fifo_in_ready);
        next_sck = smart && card_clk;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            thr <= 8'h00;
            thr_full <= 1'b0;
            shreg <= 12'hfff;
            bits_left <= 4'h0;
            tcnt <= 4'h0;
            brk_pending <= 1'b0;
            brk_stop <= 1'b0;
            brk_bits <= 8'h00;
            rx_state <= RX_IDLE;
            rsh <= 11'h000;
            rcnt <= 4'h0;
            ridx <= 4'h0;
            ncnt <= 5'h00;
            eob <= 2'h0;
            rdata <= 8'h00;
            push <= 1'b0;
            rx_prev <= 1'b1;
            frame_error_flag <= 1'b0;
            break_seen_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            error_tally <= 8'h00;
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            rts_out <= 1'b0;
            sck_out <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            thr <= next_thr;
            thr_full <= next_thr_full;
            shreg <= next_shreg;
            bits_left <= next_bits_left;
            tcnt <= next_tcnt;
            brk_pending <= next_brk_pending;
            brk_stop <= next_brk_stop;
            brk_bits <= next_brk_bits;
            rx_state <= next_rx_state;
            rsh <= next_rsh;
            rcnt <= next_rcnt;
            ridx <= next_ridx;
            ncnt <= next_ncnt;
            eob <= next_eob;
            rdata <= next_rdata;
            push <= next_push;
            rx_prev <= rx_line;
            frame_error_flag <= next_frame;
            break_seen_flag <= next_brk;
            parity_error_flag <= next_par;
            error_tally <= next_tally;
            txd_out <= next_txd_out;
            txd_oe <= next_txd_oe;
            rts_out <= next_rts;
            sck_out <= next_sck;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_frame_hold;
        frame_error_flag && !clear_status_cmd |=> frame_error_flag;
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame flag lost");
    property p_brk_low;
        tx_state == TX_BRK_LOW |=> !txd_out;
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");
    property p_brk_min;
        tx_state == TX_BRK_LOW && (brk_bits + 8'h01 < {4'h0, tx_len}) |=> tx_state == TX_BRK_LOW;
    endproperty
    a_brk_min: assert property (p_brk_min) else $error("break too short");
    property p_start_ignored;
        in_break && break_start_cmd |=> !brk_pending;
    endproperty
    a_start_ignored: assert property (p_start_ignored) else $error("start in break");
    property p_start_flags;
        brk_start_ok |=> !tx_holding_free && !tx_all_done;
    endproperty
    a_start_flags: assert property (p_start_flags) else $error("flags kept");
    property p_pending_drop;
        brk_pending && tx_write && !thr_full |=> !thr_full;
    endproperty
    a_pending_drop: assert property (p_pending_drop) else $error("byte taken");
    property p_hold_high;
        tx_state == TX_BRK_HIGH && (brk_bits + 8'h01 < hold_bits) |=> tx_state == TX_BRK_HIGH;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("high too short");
    property p_rts;
        hs && !rx_enable |=> rts_out;
    endproperty
    a_rts: assert property (p_rts) else $error("rts low");
    property p_cts;
        tx_state == TX_IDLE && hs && cts_s && !brk_pending |=> tx_state != TX_SHIFT;
    endproperty
    a_cts: assert property (p_cts) else $error("sent under cts");
    property p_release;
        smart && tx_state == TX_IDLE && rx_state != RX_NACK |=> !txd_oe;
    endproperty
    a_release: assert property (p_release) else $error("line driven");
    property p_nack;
        rx_state == RX_BITS ##1 rx_state == RX_NACK |-> parity_error_flag && !push;
    endproperty
    a_nack: assert property (p_nack) else $error("nack bad");
    property p_err_clear;
        error_count_read && !err_evt |=> error_tally == 8'h00;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("tally kept");
    c_break: cover property (tx_state == TX_BRK_HIGH ##1 tx_state == TX_IDLE);
    c_nack: cover property (nack_low);
    c_frame: cover property (set_frame);
    c_break_seen_flag: cover property (rx_state == RX_BRK ##1 rx_state == RX_IDLE);
endmodule : ubh_line

/* ubh_remote.sv */
// remote serial device model driving the receive line
`timescale 1ns/1ns
module ubh_remote (
    input wire logic clk_sys,
    input wire logic baud_tick16,
    output logic line
);
    initial line = 1'b1;
    // start, data lsb first, parity, stop; bad flips parity to provoke a nack
    task automatic send(input logic [7:0] d, input logic stp, input logic bad);
        logic [10:0] f;
        f = {stp, ^d ^ bad, d, 1'b0}; // data sent as given
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (16) @(posedge clk_sys iff baud_tick16);
        end
        line <= 1'b1; // released line rests high on its pull-up
        @(posedge clk_sys iff baud_tick16);
    endtask : send
endmodule : ubh_remote

/* ubh_line_tb.sv */
// self-checking bench for the usart line block
`timescale 1ns/1ns
module ubh_line_tb;
    import ubh_pkg::*;
    // ====
    logic clk_sys = 0, rst_n = 0, baud_tick16 = 0, card_clk = 0, par_en = 1, rem_line;
    logic rx_enable = 0, tx_enable = 1, rx_dma_buffer_full = 0, rx_ready = 0, cts_in = 0;
    logic clear_status_cmd = 0, break_start_cmd = 0, break_stop_cmd = 0, tx_write = 0;
    logic error_count_read = 0, tx_holding_free, tx_all_done, rx_valid, frame_error_flag;
    logic break_seen_flag, parity_error_flag, txd_out, txd_oe, rts_out, sck_out;
    logic [7:0] tx_data = 8'h00, tg_bits = 8'h00, rx_data, error_tally, d, b;
    ubh_mode_t op_mode = 4'h0;
    int num_errors = 0, check_count = 0, seed = 87237, n, h;
    logic [7:0] exp_q[$];
    // open-drain style wire: card and block both may pull the data line low
    wire txd_in = rem_line & (txd_oe ? txd_out : 1'b1);
    ubh_line u_ubh_line (.sync_mode(1'b0), .par_odd(1'b0), .msb_first_select(1'b0),
        .stop2(1'b0), .rxd_in(rem_line), .*);
    ubh_remote u_remote (.clk_sys(clk_sys), .baud_tick16(baud_tick16), .line(rem_line));
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) baud_tick16 <= ~baud_tick16;
    always @(posedge clk_sys) card_clk <= card_clk ^ baud_tick16;
    // ====
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic wait_txd(input logic v);
        for (int i = 0; i < 900 && txd_out !== v; i++) cyc(1);
    endtask : wait_txd
    // samples data mid-bit, 32 cycles a bit, ends inside the stop bit
    task automatic grab(output logic [7:0] g);
        wait_txd(1'b0);
        cyc(16);
        for (int i = 0; i < 8; i++) begin
            cyc(32);
            g[i] = txd_out;
        end
        cyc(64);
    endtask : grab
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #300000;
        num_errors++;
        $display("watchdog expired");
        finish_test();
    end
    // ====
    initial begin
        cyc(5);
        rst_n = 1'b1;
        op_mode = MODE_HANDSHAKE;
        cyc(4);
        check(rts_out, 1);
        rx_enable = 1'b1;
        cyc(4);
        check(rts_out, 0);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            exp_q.push_back(d);
            u_remote.send(d, 1'b1, 1'b0);
        end
        cyc(4);
        check(rts_out, 1);
        while (exp_q.size() > 0) begin
            for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) cyc(1);
            check(rx_data, exp_q.pop_front());
            pulse(rx_ready);
            cyc(1);
        end
        check(rts_out, 0);
        rx_dma_buffer_full = 1'b1;
        cyc(2);
        check(rts_out, 1);
        rx_dma_buffer_full = 1'b0;
        cts_in = 1'b1;
        cyc(8);
        check(rts_out, 0);
        tx_data = d;
        pulse(tx_write);
        cyc(100);
        check(txd_out, 1);
        cts_in = 1'b0;
        grab(b);
        check(b, d);
        $display("test handshake done");
        op_mode = 4'h0;
        rx_ready = 1'b1;
        u_remote.send(8'h55, 1'b0, 1'b0);
        cyc(2);
        check({frame_error_flag, break_seen_flag, error_tally}, 10'h201);
        pulse(clear_status_cmd);
        check(frame_error_flag, 0);
        u_remote.send(8'h00, 1'b0, 1'b0);
        check({break_seen_flag, frame_error_flag}, 2'b10);
        pulse(error_count_read);
        check(error_tally, 0);
        check(sck_out, 0);
        $display("test receive errors done");
        tg_bits = 8'h08 + {4'h0, 4'($random(seed))};
        h = (tg_bits > 12) ? tg_bits : 12;
        d = $random(seed);
        tx_data = d;
        pulse(tx_write);
        wait_txd(1'b0);
        pulse(break_start_cmd);
        check({tx_holding_free, tx_all_done}, 2'b00);
        tx_data = ~d;
        pulse(tx_write);
        grab(b);
        check(b, d);
        wait_txd(1'b0);
        pulse(break_stop_cmd); // never with start
        pulse(break_start_cmd);
        for (n = 2; txd_out === 1'b0 && n < 2000; n++) cyc(1);
        check(n >= 350 && n < 384, 1);
        d = $random(seed);
        tx_data = d;
        pulse(tx_write);
        for (n = 1; txd_out === 1'b1 && n < 2000; n++) cyc(1);
        check(n >= 32 * h && n <= 32 * h + 4, 1);
        grab(b);
        check(b, d);
        $display("test transmit break done");
        op_mode = MODE_T0;
        tx_enable = 1'b0;
        rx_ready = 1'b0;
        cyc(40);
        check(txd_oe, 0);
        for (int i = 0; i < 4; i++) begin
            b[0] = card_clk;
            cyc(1);
            check(sck_out, b[0]);
        end
        n = 0;
        fork
            u_remote.send(8'ha5, 1'b1, 1'b1);
            repeat (600) begin
                cyc(1);
                if (txd_oe === 1'b1 && txd_out === 1'b0) n++;
            end
        join
        check(n >= 30 && n <= 34, 1);
        check({parity_error_flag, rx_valid, error_tally}, 10'h201);
        $display("test smart card done");
        finish_test();
    end
endmodule : ubh_line_tb
